// File: rdq_pkg.sv
// Package for the receive descriptor queue pointer bank
package rdq_pkg;
   localparam int ADDR_W = 12;
   localparam int FIELD_W = 16;
   localparam int PHYS_W = 32;
   localparam int SHIFT = 2;
   localparam int NREG = 5;
   localparam int IDX_W = 3;
   // Register byte offsets
   localparam logic [11:0] OFF_SF_WRITE = 12'h2AC;
   localparam logic [11:0] OFF_SF_READ = 12'h2B0;
   localparam logic [11:0] OFF_SF_END = 12'h2B4;
   localparam logic [11:0] OFF_RQ_START = 12'h2B8;
   localparam logic [11:0] OFF_RQ_WRITE = 12'h2BC;
   // Register indices in the bank
   localparam logic [2:0] IDX_SF_WRITE = 3'h0;
   localparam logic [2:0] IDX_SF_READ = 3'h1;
   localparam logic [2:0] IDX_SF_END = 3'h2;
   localparam logic [2:0] IDX_RQ_START = 3'h3;
   localparam logic [2:0] IDX_RQ_WRITE = 3'h4;
   localparam logic [2:0] IDX_NONE = 3'h7;
   localparam logic [15:0] FIELD_RST = 16'h0000;
   localparam logic [3:0] BE_NONE_N = 4'hF;
   localparam logic [31:0] DATA_RST = 32'h0000_0000;
   // Least spacing between writes to one register, in ns and cycles
   localparam int CLK_NS = 25;
   localparam int WR_GAP_NS = 100;
   localparam int WR_GAP_CYC = (WR_GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0] GAP_CNT = 3'(WR_GAP_CYC);
   typedef enum logic [1:0] {
      RDQ_ADV_NONE,
      RDQ_ADV_SF_WRITE,
      RDQ_ADV_SF_READ,
      RDQ_ADV_RQ_WRITE
   } rdq_adv_e;
endpackage

// File: rdq_regfile.sv
// Small register memory holding the five pointer fields
`timescale 1ns/1ps
module rdq_regfile (
   input wire logic clk,
   input wire logic srst,
   input wire logic wr_en,
   input wire logic [2:0] wr_idx,
   input wire logic [15:0] wr_data,
   input wire logic [2:0] rd_idx,
   output logic [15:0] rd_data,
   output logic [79:0] all_q
);
   logic [15:0] mem_q [0:rdq_pkg::NREG-1];

   genvar g;
   generate
      for (g = 0; g < rdq_pkg::NREG; g++) begin : g_reg
         always_ff @(posedge clk) begin
            if (srst) begin
               mem_q[g] <= rdq_pkg::FIELD_RST;
            end else if (wr_en && wr_idx == 3'(g)) begin
               mem_q[g] <= wr_data;
            end
         end
         assign all_q[g*16 +: 16] = mem_q[g];
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (srst) begin
         rd_data <= rdq_pkg::FIELD_RST;
      end else if (rd_idx < 3'(rdq_pkg::NREG)) begin
         rd_data <= mem_q[rd_idx];
      end else begin
         rd_data <= rdq_pkg::FIELD_RST;
      end
   end
endmodule

// File: rdq_bank.sv
// Receive descriptor queue pointer bank: registers, address forming, wrap
//
// Contract
// - Pointer fields are 16 bits, address bits 17:2.
// - Address equals base plus field shifted two.
// - Writes update the whole register, no lanes.
// - All byte enables negated means no access.
// - Small free queue write pointer register provided.
// - Small free queue end register provided.
// - Ready queue start register provided.
// - Ready queue write pointer register provided.
`timescale 1ns/1ps
module rdq_bank (
   input wire logic clk,
   input wire logic srst,
   input wire logic bus_sel,
   input wire logic bus_wr,
   input wire logic [11:0] bus_addr,
   input wire logic [3:0] bus_byte_enables_n,
   input wire logic [31:0] bus_wdata,
   output logic [31:0] bus_rdata,
   output logic bus_rvalid,
   input wire logic [31:0] receive_queue_base,
   input wire logic [15:0] small_free_start_field,
   input wire logic [15:0] ready_end_field,
   input wire logic adv_req,
   input wire logic [1:0] adv_sel,
   output logic [31:0] sf_write_addr,
   output logic [31:0] sf_read_addr,
   output logic [31:0] sf_end_addr,
   output logic [31:0] rq_start_addr,
   output logic [31:0] rq_write_addr,
   output logic wr_gap_err
);
   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   function automatic logic [2:0] decode_idx(input logic [11:0] a);
      logic [2:0] r;
      r = rdq_pkg::IDX_NONE;
      case (a)
         rdq_pkg::OFF_SF_WRITE: r = rdq_pkg::IDX_SF_WRITE;
         rdq_pkg::OFF_SF_READ: r = rdq_pkg::IDX_SF_READ;
         rdq_pkg::OFF_SF_END: r = rdq_pkg::IDX_SF_END;
         rdq_pkg::OFF_RQ_START: r = rdq_pkg::IDX_RQ_START;
         rdq_pkg::OFF_RQ_WRITE: r = rdq_pkg::IDX_RQ_WRITE;
         default: r = rdq_pkg::IDX_NONE;
      endcase
      return r;
   endfunction

   // Physical address from a pointer field
   function automatic logic [31:0] phys(input logic [31:0] base, input logic [15:0] f);
      return base + {14'h0000, f, 2'h0};
   endfunction

   wire [2:0] bus_idx = decode_idx(bus_addr);
   wire be_any = (bus_byte_enables_n != rdq_pkg::BE_NONE_N);
   wire bus_hit = bus_sel && be_any && (bus_idx != rdq_pkg::IDX_NONE);
   wire host_wr = bus_hit && bus_wr;
   wire host_rd = bus_hit && !bus_wr;

   // ------------------------------------------------------------
   // Pointer advance with wrap
   // ------------------------------------------------------------
   logic [79:0] all_q;
   logic [15:0] rd_field;
   wire [15:0] f_sfw = all_q[16*rdq_pkg::IDX_SF_WRITE +: 16];
   wire [15:0] f_sfr = all_q[16*rdq_pkg::IDX_SF_READ +: 16];
   wire [15:0] f_sfe = all_q[16*rdq_pkg::IDX_SF_END +: 16];
   wire [15:0] f_rqs = all_q[16*rdq_pkg::IDX_RQ_START +: 16];
   wire [15:0] f_rqw = all_q[16*rdq_pkg::IDX_RQ_WRITE +: 16];

   wire adv_sfw = adv_sel == rdq_pkg::RDQ_ADV_SF_WRITE;
   wire adv_sfr = adv_sel == rdq_pkg::RDQ_ADV_SF_READ;
   wire adv_rqw = adv_sel == rdq_pkg::RDQ_ADV_RQ_WRITE;
   wire [15:0] adv_cur = adv_sfw ? f_sfw : (adv_sfr ? f_sfr : f_rqw);
   wire [15:0] adv_end = adv_rqw ? ready_end_field : f_sfe;
   wire [15:0] adv_start = adv_rqw ? f_rqs : small_free_start_field;
   wire [15:0] adv_next = (adv_cur == adv_end) ? adv_start : adv_cur + 16'h0001;
   wire [2:0] adv_idx = adv_sfw ? rdq_pkg::IDX_SF_WRITE :
                        (adv_sfr ? rdq_pkg::IDX_SF_READ : rdq_pkg::IDX_RQ_WRITE);
   wire adv_go = adv_req && (adv_sel != rdq_pkg::RDQ_ADV_NONE) && !host_wr;

   // Whole-word write, byte lanes ignored; host wins over advance
   wire rf_wr = host_wr || adv_go;
   wire [2:0] rf_idx = host_wr ? bus_idx : adv_idx;
   wire [15:0] rf_data = host_wr ? bus_wdata[15:0] : adv_next;

   rdq_regfile u_regfile (
      .clk(clk),
      .srst(srst),
      .wr_en(rf_wr),
      .wr_idx(rf_idx),
      .wr_data(rf_data),
      .rd_idx(bus_idx),
      .rd_data(rd_field),
      .all_q(all_q)
   );

   // ------------------------------------------------------------
   // Read response and write spacing monitor
   // ------------------------------------------------------------
   logic rd_pend_q;
   logic [2:0] gap_q [0:rdq_pkg::NREG-1];
   logic [rdq_pkg::NREG-1:0] gap_hit;

   genvar g;
   generate
      for (g = 0; g < rdq_pkg::NREG; g++) begin : g_gap
         assign gap_hit[g] = host_wr && bus_idx == 3'(g) && gap_q[g] != 3'h0;
         always_ff @(posedge clk) begin
            if (srst) begin
               gap_q[g] <= 3'h0;
            end else if (host_wr && bus_idx == 3'(g)) begin
               gap_q[g] <= rdq_pkg::GAP_CNT - 3'h1;
            end else if (gap_q[g] != 3'h0) begin
               gap_q[g] <= gap_q[g] - 3'h1;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (srst) begin
         rd_pend_q <= 1'b0;
         bus_rvalid <= 1'b0;
         bus_rdata <= rdq_pkg::DATA_RST;
         wr_gap_err <= 1'b0;
      end else begin
         rd_pend_q <= host_rd;
         bus_rvalid <= rd_pend_q;
         bus_rdata <= rd_pend_q ? {16'h0000, rd_field} : rdq_pkg::DATA_RST;
         wr_gap_err <= |gap_hit;
      end
   end

   // ------------------------------------------------------------
   // Physical addresses
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         sf_write_addr <= rdq_pkg::DATA_RST;
         sf_read_addr <= rdq_pkg::DATA_RST;
         sf_end_addr <= rdq_pkg::DATA_RST;
         rq_start_addr <= rdq_pkg::DATA_RST;
         rq_write_addr <= rdq_pkg::DATA_RST;
      end else begin
         sf_write_addr <= phys(receive_queue_base, f_sfw);
         sf_read_addr <= phys(receive_queue_base, f_sfr);
         sf_end_addr <= phys(receive_queue_base, f_sfe);
         rq_start_addr <= phys(receive_queue_base, f_rqs);
         rq_write_addr <= phys(receive_queue_base, f_rqw);
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_no_be_write: assert property (@(posedge clk) disable iff (srst)
      (bus_sel && bus_wr && !adv_req && bus_byte_enables_n == rdq_pkg::BE_NONE_N)
      |=> $stable(all_q))
      else $error("write with no byte enables changed a register");
   a_rd_two_cyc: assert property (@(posedge clk) disable iff (srst)
      host_rd |-> ##2 bus_rvalid)
      else $error("read answer not two cycles later");
   a_rd_none_be: assert property (@(posedge clk) disable iff (srst)
      (!host_rd ##1 1'b1) |=> !bus_rvalid)
      else $error("read answer without a taken read");
   a_whole_word: assert property (@(posedge clk) disable iff (srst)
      (host_wr && bus_idx == rdq_pkg::IDX_SF_END) |=> f_sfe == $past(bus_wdata[15:0]))
      else $error("end register not fully written");
   a_addr_form: assert property (@(posedge clk) disable iff (srst)
      ##1 rq_write_addr == $past(receive_queue_base) + {14'h0000, $past(f_rqw), 2'h0})
      else $error("ready write address misformed");
   a_sf_wrap: assert property (@(posedge clk) disable iff (srst)
      (adv_go && adv_sfw && f_sfw == f_sfe) |=> f_sfw == $past(small_free_start_field))
      else $error("small free write pointer did not wrap");
   a_rq_step: assert property (@(posedge clk) disable iff (srst)
      (adv_go && adv_rqw && f_rqw != ready_end_field) |=> f_rqw == $past(f_rqw) + 16'h0001)
      else $error("ready write pointer did not step");
   a_rq_start_hold: assert property (@(posedge clk) disable iff (srst)
      !(host_wr && bus_idx == rdq_pkg::IDX_RQ_START) |=> $stable(f_rqs))
      else $error("ready start changed without a write");
   a_gap_flag: assert property (@(posedge clk) disable iff (srst)
      (host_wr && bus_idx == rdq_pkg::IDX_SF_END) ##[1:3]
      (host_wr && bus_idx == rdq_pkg::IDX_SF_END)
      |=> wr_gap_err)
      else $error("close writes not flagged");
endmodule

// File: rdq_bank_tb.sv
// Self-checking testbench for the queue pointer bank
`timescale 1ns/1ps
module rdq_bank_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic bus_sel = 1'b0;
   logic bus_wr = 1'b0;
   logic [11:0] bus_addr = 12'h000;
   logic [3:0] be_n = 4'hF;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] base = 32'h0000_0000;
   logic [15:0] sf_start = 16'h0000;
   logic [15:0] rq_end = 16'h0000;
   logic adv_req = 1'b0;
   logic [1:0] adv_sel = 2'h0;
   logic [31:0] rdata;
   logic rvalid;
   logic gap_err;
   wire [31:0] aout [0:4];
   logic [11:0] offs [0:4];
   int fail_count = 0;
   int compares = 0;
   int gap_seen = 0;
   always #12.5 clk = ~clk;
   always @(posedge clk) if (gap_err === 1'b1) gap_seen++;
   rdq_bank DUT (.clk(clk), .srst(srst), .bus_sel(bus_sel), .bus_wr(bus_wr),
      .bus_addr(bus_addr), .bus_byte_enables_n(be_n), .bus_wdata(wdata),
      .bus_rdata(rdata), .bus_rvalid(rvalid), .receive_queue_base(base),
      .small_free_start_field(sf_start), .ready_end_field(rq_end), .adv_req(adv_req),
      .adv_sel(adv_sel), .sf_write_addr(aout[0]), .sf_read_addr(aout[1]),
      .sf_end_addr(aout[2]), .rq_start_addr(aout[3]), .rq_write_addr(aout[4]),
      .wr_gap_err(gap_err));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b, input int idle);
      @(negedge clk);
      bus_sel = 1'b1; bus_wr = 1'b1; bus_addr = a; be_n = b; wdata = d;
      @(negedge clk);
      bus_sel = 1'b0; bus_wr = 1'b0;
      repeat (idle) @(negedge clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [3:0] b, input logic ev, output logic [31:0] d);
      logic got;
      got = 1'b0;
      d = 32'h0000_0000;
      @(negedge clk);
      bus_sel = 1'b1; bus_wr = 1'b0; bus_addr = a; be_n = b;
      @(negedge clk);
      bus_sel = 1'b0;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk); #1;
         if (rvalid === 1'b1) begin got = 1'b1; d = rdata; end
      end
      check("read valid", {31'h0, ev}, {31'h0, got});
      if (ev && !got) finish_test();
   endtask
   // Field read back and its address output
   task automatic rdchk(input int k, input logic [15:0] f);
      logic [31:0] d;
      rd(offs[k], 4'h0, 1'b1, d);
      check("field", {16'h0000, f}, d);
      check("address", base + {14'h0, f, 2'b00}, aout[k]);
   endtask
   task automatic adv(input logic [1:0] s);
      @(negedge clk);
      adv_req = 1'b1; adv_sel = s;
      @(negedge clk);
      adv_req = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      for (int k = 0; k < 5; k++) rdchk(k, 16'h0000);
      $display("reset values done");
   endtask
   task automatic t_rw;
      logic [31:0] d;
      @(negedge clk);
      base = 32'h8000_1000;
      for (int k = 0; k < 5; k++) begin
         wr(offs[k], {16'hA5A5, 16'h8001 + 16'(k) * 16'h1111}, 4'hE, 3);
         rdchk(k, 16'h8001 + 16'(k) * 16'h1111);
         wr(offs[k], 32'h0000_5555, 4'hF, 3);
         rdchk(k, 16'h8001 + 16'(k) * 16'h1111);
      end
      @(negedge clk);
      base = 32'h0000_0F04;
      repeat (2) @(negedge clk);
      for (int k = 0; k < 5; k++)
         check("rebased", base + {14'h0, 16'h8001 + 16'(k) * 16'h1111, 2'b00}, aout[k]);
      rd(12'h2C0, 4'h0, 1'b0, d);
      rd(offs[1], 4'hF, 1'b0, d);
      $display("read write done");
   endtask
   task automatic t_wrap;
      @(negedge clk);
      sf_start = 16'h0010;
      rq_end = 16'h0040;
      wr(offs[2], 32'h0000_0020, 4'h0, 3);
      wr(offs[1], 32'h0000_0020, 4'h0, 3);
      adv(2'h2);
      rdchk(1, 16'h0010);
      wr(offs[0], 32'h0000_001F, 4'h0, 3);
      adv(2'h1);
      rdchk(0, 16'h0020);
      adv(2'h1);
      rdchk(0, 16'h0010);
      wr(offs[3], 32'h0000_0030, 4'h0, 3);
      wr(offs[4], 32'h0000_0040, 4'h0, 3);
      adv(2'h3);
      rdchk(4, 16'h0030);
      adv(2'h3);
      rdchk(4, 16'h0031);
      adv(2'h0);
      rdchk(4, 16'h0031);
      $display("wrap done");
   endtask
   task automatic t_gap;
      int seen;
      check("early gap flag", 32'h0, 32'(gap_seen));
      seen = gap_seen;
      wr(offs[2], 32'h0000_1111, 4'h0, 1);
      wr(offs[2], 32'h0000_2222, 4'h0, 0);
      repeat (4) @(negedge clk);
      check("gap flag", 32'h1, 32'(gap_seen - seen));
      rdchk(2, 16'h2222);
      seen = gap_seen;
      wr(offs[3], 32'h0000_0031, 4'h0, 2);
      wr(offs[3], 32'h0000_0030, 4'h0, 3);
      check("spaced writes", 32'h0, 32'(gap_seen - seen));
      $display("write spacing done");
   endtask
   initial begin
      offs[0] = rdq_pkg::OFF_SF_WRITE;
      offs[1] = rdq_pkg::OFF_SF_READ;
      offs[2] = rdq_pkg::OFF_SF_END;
      offs[3] = rdq_pkg::OFF_RQ_START;
      offs[4] = rdq_pkg::OFF_RQ_WRITE;
      repeat (4) @(negedge clk);
      srst = 1'b0;
      t_reset();
      t_rw();
      t_wrap();
      t_gap();
      finish_test();
   end
endmodule
